/* rtl/udtc_pkg.sv */
// Package of constants and carrier types for the up/down target counter
package udtc_pkg;
    // Register byte offsets
    localparam logic [7:0]  ADDR_CTRL     = 8'h00;
    localparam logic [7:0]  ADDR_TARGET   = 8'h04;
    localparam logic [7:0]  ADDR_COUNT    = 8'h08;
    localparam logic [7:0]  ADDR_STATUS   = 8'h0c;
    // Control field positions
    localparam int          CTRL_ENABLE   = 0;
    localparam int          CTRL_DIR      = 1;
    localparam int          CTRL_RESET    = 2;
    localparam int          CTRL_CLR_OVF  = 3;
    // Status field positions
    localparam int          STAT_CARRY    = 0;
    localparam int          STAT_OVF      = 1;
    // Counter width and limits
    localparam int          CNT_W         = 17;
    localparam logic [16:0] CNT_MAX       = 17'h1869f;
    localparam logic [16:0] TARGET_RST    = 17'h0270f;
    // Direction encoding
    localparam logic        DIR_UP        = 1'b0;

    // Configuration carried from bus slave to counter core
    typedef struct packed {
        logic              count_enable;
        logic              dir_down;
        logic              counter_reset;
        logic              clear_overflow;
        logic [CNT_W-1:0]  count_target;
    } udtc_cfg_t;

    // Status carried from counter core to bus slave
    typedef struct packed {
        logic              ripple_carry_flag;
        logic              overflow_flag;
        logic [CNT_W-1:0]  count;
    } udtc_stat_t;
endpackage

/* rtl/udtc_edge.sv */
// Two-stage synchroniser with rising-edge detector for the count input
`timescale 1ns/1ps
`default_nettype none
module udtc_edge (
    input  wire logic i_clk_sys,  // System clock
    input  wire logic i_srst,     // Sync reset, active high
    input  wire logic i_pin,      // Asynchronous count input
    output logic      o_rise      // One-cycle pulse on rising edge
);
    typedef struct packed {
        logic meta;
        logic sync;
        logic prev;
        logic rise;
    } udtc_edge_st_t;

    udtc_edge_st_t st_q;
    udtc_edge_st_t st_d;

    // First stage feeds only the second stage
    always_comb begin
        st_d      = st_q;
        st_d.meta = i_pin;
        st_d.sync = st_q.meta;
        st_d.prev = st_q.sync;
        st_d.rise = st_q.sync & ~st_q.prev;
    end

    always_ff @(posedge i_clk_sys) begin
        if (i_srst) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign o_rise = st_q.rise;
endmodule
`default_nettype wire

/* rtl/udtc_core.sv */
// Counting core: direction, target, ripple carry and overflow
`timescale 1ns/1ps
`default_nettype none
module udtc_core (
    input  wire logic               i_clk_sys,  // System clock
    input  wire logic               i_srst,     // Sync reset, active high
    input  wire logic               i_event,    // Counted edge pulse
    input  wire udtc_pkg::udtc_cfg_t i_cfg,     // Settings
    output udtc_pkg::udtc_stat_t    o_stat      // Count and flags
);
    udtc_pkg::udtc_stat_t st_q;
    udtc_pkg::udtc_stat_t st_d;

    always_comb begin
        st_d = st_q;
        if (i_cfg.clear_overflow) begin
            st_d.overflow_flag = 1'b0;
        end
        if (i_cfg.counter_reset) begin
            st_d.count         = (i_cfg.dir_down != udtc_pkg::DIR_UP) ? i_cfg.count_target : '0;
            st_d.overflow_flag = 1'b0;
        end else if (i_cfg.count_enable && i_event) begin
            if (i_cfg.dir_down == udtc_pkg::DIR_UP) begin
                if (st_q.count >= i_cfg.count_target || st_q.count >= udtc_pkg::CNT_MAX) begin
                    st_d.count         = '0;
                    st_d.overflow_flag = 1'b1;
                end else begin
                    st_d.count = st_q.count + 17'h00001;
                end
            end else begin
                if (st_q.count == '0) begin
                    st_d.count         = i_cfg.count_target;
                    st_d.overflow_flag = 1'b1;
                end else begin
                    st_d.count = st_q.count - 17'h00001;
                end
            end
        end
        if (i_cfg.dir_down == udtc_pkg::DIR_UP) begin
            st_d.ripple_carry_flag = (st_d.count == i_cfg.count_target);
        end else begin
            st_d.ripple_carry_flag = (st_d.count == '0);
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (i_srst) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign o_stat = st_q;
endmodule
`default_nettype wire

/* rtl/udtc_top.sv */
// Top level: APB register slave around the up/down target counter
//
// The implementer's own choices: the APB slave port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module udtc_top (
    input  wire logic        i_clk_sys,     // 20 MHz system clock
    input  wire logic        i_srst,        // Sync reset, active high
    input  wire logic        i_count_in,    // Counted input pin
    input  wire logic        i_psel,        // APB select
    input  wire logic        i_penable,     // APB enable
    input  wire logic        i_pwrite,      // APB write
    input  wire logic [7:0]  i_paddr,       // APB byte address
    input  wire logic [31:0] i_pwdata,      // APB write data
    output logic             o_pready,      // APB ready
    output logic [31:0]      o_prdata,      // APB read data
    output logic             o_pslverr,     // APB error, unmapped
    output logic             o_ripple_carry,// Carry flag
    output logic             o_overflow     // Overflow flag
);
    typedef struct packed {
        udtc_pkg::udtc_cfg_t cfg;
        logic                pready;
        logic                pslverr;
        logic [31:0]         prdata;
        logic                carry;
        logic                ovf;
    } udtc_top_st_t;

    udtc_top_st_t         st_q;
    udtc_top_st_t         st_d;
    logic                 rise;
    udtc_pkg::udtc_stat_t stat;

    // Address decode shared by read and write paths
    function automatic logic is_mapped(input logic [7:0] a);
        return a == udtc_pkg::ADDR_CTRL || a == udtc_pkg::ADDR_TARGET ||
               a == udtc_pkg::ADDR_COUNT || a == udtc_pkg::ADDR_STATUS;
    endfunction

    udtc_edge u_edge (
        .i_clk_sys (i_clk_sys),
        .i_srst    (i_srst),
        .i_pin     (i_count_in),
        .o_rise    (rise)
    );

    udtc_core u_core (
        .i_clk_sys (i_clk_sys),
        .i_srst    (i_srst),
        .i_event   (rise),
        .i_cfg     (st_q.cfg),
        .o_stat    (stat)
    );

    // Bus slave: one wait state, answer in the second access cycle
    always_comb begin
        st_d                    = st_q;
        st_d.pready             = 1'b0;
        st_d.pslverr            = 1'b0;
        // Clear-overflow acts as a one-cycle strobe
        st_d.cfg.clear_overflow = 1'b0;
        st_d.carry              = stat.ripple_carry_flag;
        st_d.ovf                = stat.overflow_flag;
        if (i_psel && i_penable && !st_q.pready) begin
            st_d.pready  = 1'b1;
            st_d.pslverr = !is_mapped(i_paddr);
            st_d.prdata  = '0;
            if (i_pwrite) begin
                unique case (i_paddr)
                    udtc_pkg::ADDR_CTRL: begin
                        st_d.cfg.count_enable   = i_pwdata[udtc_pkg::CTRL_ENABLE];
                        st_d.cfg.dir_down       = i_pwdata[udtc_pkg::CTRL_DIR];
                        st_d.cfg.counter_reset  = i_pwdata[udtc_pkg::CTRL_RESET];
                        st_d.cfg.clear_overflow = i_pwdata[udtc_pkg::CTRL_CLR_OVF];
                    end
                    udtc_pkg::ADDR_TARGET: begin
                        if (i_pwdata[16:0] > udtc_pkg::CNT_MAX || i_pwdata[31:17] != '0) begin
                            st_d.cfg.count_target = udtc_pkg::CNT_MAX;
                        end else begin
                            st_d.cfg.count_target = i_pwdata[16:0];
                        end
                    end
                    default: begin
                    end
                endcase
            end else begin
                unique case (i_paddr)
                    udtc_pkg::ADDR_CTRL: begin
                        st_d.prdata[udtc_pkg::CTRL_ENABLE] = st_q.cfg.count_enable;
                        st_d.prdata[udtc_pkg::CTRL_DIR]    = st_q.cfg.dir_down;
                        st_d.prdata[udtc_pkg::CTRL_RESET]  = st_q.cfg.counter_reset;
                    end
                    udtc_pkg::ADDR_TARGET: begin
                        st_d.prdata[16:0] = st_q.cfg.count_target;
                    end
                    udtc_pkg::ADDR_COUNT: begin
                        st_d.prdata[16:0] = stat.count;
                    end
                    udtc_pkg::ADDR_STATUS: begin
                        st_d.prdata[udtc_pkg::STAT_CARRY] = stat.ripple_carry_flag;
                        st_d.prdata[udtc_pkg::STAT_OVF]   = stat.overflow_flag;
                    end
                    default: begin
                    end
                endcase
            end
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (i_srst) begin
            st_q                  <= '0;
            st_q.cfg.count_target <= udtc_pkg::TARGET_RST;
        end else begin
            st_q <= st_d;
        end
    end

    assign o_pready       = st_q.pready;
    assign o_prdata       = st_q.prdata;
    assign o_pslverr      = st_q.pslverr;
    assign o_ripple_carry = st_q.carry;
    assign o_overflow     = st_q.ovf;
endmodule
`default_nettype wire

/* dv/udtc_pin_src.sv */
// Model of the digital input wired to the count pin
`timescale 1ns/1ps
`default_nettype none
module udtc_pin_src (
    input  wire logic i_clk_sys, // System clock
    output var logic  o_pin      // Count pin level
);
    initial o_pin = 1'b0;
    // whole pulses
    // Three clocks high, three low, so the synchroniser never misses a level
    task automatic pulse(input int n);
        repeat (n) begin
            @(posedge i_clk_sys) o_pin <= 1'b1;
            repeat (3) @(posedge i_clk_sys);
            o_pin <= 1'b0;
            repeat (3) @(posedge i_clk_sys);
        end
    endtask
endmodule
`default_nettype wire

/* dv/udtc_properties.sv */
// Checker for bus handshake and counter flags of udtc_top
`timescale 1ns/1ps
`default_nettype none
module udtc_properties (
    input wire logic        i_clk_sys,      // Clock
    input wire logic        i_srst,         // Reset
    input wire logic        i_count_in,     // Pin
    input wire logic        i_psel,         // Select
    input wire logic        i_penable,      // Enable
    input wire logic        i_pwrite,       // Write
    input wire logic        o_pready,       // Ready
    input wire logic [31:0] o_prdata,       // Read data
    input wire logic        o_pslverr,      // Error
    input wire logic        o_ripple_carry, // Carry
    input wire logic        o_overflow      // Overflow
);
    logic       pin_q;
    logic [3:0] rise_age_q;
    logic [3:0] wr_age_q;
    // Saturating ages, so a stale cause never excuses a flag change
    always_ff @(posedge i_clk_sys) begin
        pin_q      <= i_count_in;
        rise_age_q <= i_srst ? 4'hf : (i_count_in && !pin_q) ? 4'h0 : rise_age_q + {3'h0, rise_age_q != 4'hf};
        wr_age_q   <= i_srst ? 4'hf : (i_psel && i_pwrite && o_pready) ? 4'h0 : wr_age_q + {3'h0, wr_age_q != 4'hf};
    end
    default clocking @(posedge i_clk_sys); endclocking
    default disable iff (i_srst);
    a_ready_one_wait: assert property (i_psel && i_penable && !o_pready |=> o_pready)
        else $error("ready missing after wait");
    a_ready_pulse: assert property (o_pready |=> !o_pready)
        else $error("ready longer than one cycle");
    a_err_with_ready: assert property (o_pslverr |-> o_pready && $past(i_psel && i_penable))
        else $error("error outside an access");
    a_err_reads_zero: assert property (o_pready && o_pslverr && !$past(i_pwrite) |-> o_prdata == 32'h0)
        else $error("unmapped read not zero");
    a_ovf_has_event: assert property ($rose(o_overflow) |-> rise_age_q <= 4'h8)
        else $error("overflow without an edge");
    a_ovf_drops_carry: assert property ($rose(o_overflow) |-> !o_ripple_carry)
        else $error("carry left on at overflow");
    a_ovf_latched: assert property ($fell(o_overflow) |-> wr_age_q <= 4'h5)
        else $error("overflow fell without a write");
    a_carry_cause: assert property ($changed(o_ripple_carry) |-> rise_age_q <= 4'h8 || wr_age_q <= 4'h5)
        else $error("carry moved without cause");
    c_overflow: cover property ($rose(o_overflow));
    c_carry: cover property ($rose(o_ripple_carry));
    c_unmapped: cover property (o_pslverr);
endmodule
bind udtc_top udtc_properties u_chk (.i_clk_sys(i_clk_sys), .i_srst(i_srst), .i_count_in(i_count_in),
    .i_psel(i_psel), .i_penable(i_penable), .i_pwrite(i_pwrite), .o_pready(o_pready), .o_prdata(o_prdata),
    .o_pslverr(o_pslverr), .o_ripple_carry(o_ripple_carry), .o_overflow(o_overflow));
`default_nettype wire

/* dv/tb_up_down_target_counter.sv */
// Self-checking bench for the up/down target counter
`timescale 1ns/1ps
`default_nettype none
module tb_up_down_target_counter;
    logic        clk, srst, psel, penable, pwrite, pin, pready, pslverr, carry, ovf, last_err;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata;
    int          mismatches, n_compared;
    udtc_top uut (.i_clk_sys(clk), .i_srst(srst), .i_count_in(pin), .i_psel(psel), .i_penable(penable),
        .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_pready(pready), .o_prdata(prdata),
        .o_pslverr(pslverr), .o_ripple_carry(carry), .o_overflow(ovf));
    udtc_pin_src src (.i_clk_sys(clk), .o_pin(pin));
    // 50 ns period clock
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            mismatches++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // One transfer; request held until ready is sampled at an edge
    // No local limit: only the watchdog may end a wait for ready
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        r = prdata;
        last_err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        apb(1'b1, a, d, r);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] r;
        apb(1'b0, a, 32'h0, r);
        chk(r, e);
    endtask
    // Status read plus the flag pins, which must agree
    task automatic st(input logic [31:0] e);
        rd(udtc_pkg::ADDR_STATUS, e);
        chk({30'h0, ovf, carry}, e);
    endtask
    task automatic stop_test;
        $display("compared %0d mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    // Watchdog: tests need about 250 cycles
    initial begin
        #200000;
        mismatches++;
        stop_test();
    end
    initial begin
        {srst, psel, penable, pwrite, paddr, pwdata} = {4'h8, 8'h00, 32'h0};
        mismatches = 0;
        n_compared = 0;
        repeat (12) @(posedge clk);
        srst <= 1'b0;
        rd(udtc_pkg::ADDR_TARGET, 32'h0000270f);
        rd(udtc_pkg::ADDR_CTRL, 32'h0);
        st(32'h0);
        src.pulse(2);
        rd(udtc_pkg::ADDR_COUNT, 32'h0);
        $display("defaults and disable done");
        wr(udtc_pkg::ADDR_TARGET, 32'h3);
        wr(udtc_pkg::ADDR_CTRL, 32'h1);
        src.pulse(2);
        rd(udtc_pkg::ADDR_COUNT, 32'h2);
        st(32'h0);
        src.pulse(1);
        st(32'h1);
        wr(udtc_pkg::ADDR_COUNT, 32'h7);
        rd(udtc_pkg::ADDR_COUNT, 32'h3);
        src.pulse(1);
        rd(udtc_pkg::ADDR_COUNT, 32'h0);
        st(32'h2);
        src.pulse(1);
        st(32'h2);
        wr(udtc_pkg::ADDR_CTRL, 32'h9);
        rd(udtc_pkg::ADDR_COUNT, 32'h1);
        st(32'h0);
        $display("up counting done");
        wr(udtc_pkg::ADDR_CTRL, 32'h3);
        src.pulse(1);
        rd(udtc_pkg::ADDR_COUNT, 32'h0);
        st(32'h1);
        src.pulse(1);
        rd(udtc_pkg::ADDR_COUNT, 32'h3);
        st(32'h2);
        wr(udtc_pkg::ADDR_CTRL, 32'h7);
        src.pulse(1);
        rd(udtc_pkg::ADDR_COUNT, 32'h3);
        st(32'h0);
        wr(udtc_pkg::ADDR_CTRL, 32'h5);
        rd(udtc_pkg::ADDR_COUNT, 32'h0);
        $display("down counting and reset done");
        wr(udtc_pkg::ADDR_TARGET, 32'h0001ffff);
        rd(udtc_pkg::ADDR_TARGET, 32'h0001869f);
        rd(8'h10, 32'h0);
        chk({31'h0, last_err}, 32'h1);
        rd(8'hf0, 32'h0);
        chk({31'h0, last_err}, 32'h1);
        $display("target range and unmapped done");
        // Leave overflow and a full count standing, so the reset below has work to do
        wr(udtc_pkg::ADDR_CTRL, 32'h3);
        src.pulse(1);
        rd(udtc_pkg::ADDR_COUNT, 32'h0001869f);
        st(32'h2);
        // Second reset in mid-run must bring back every default
        @(posedge clk);
        srst <= 1'b1;
        repeat (3) @(posedge clk);
        srst <= 1'b0;
        rd(udtc_pkg::ADDR_TARGET, 32'h0000270f);
        rd(udtc_pkg::ADDR_CTRL, 32'h0);
        rd(udtc_pkg::ADDR_COUNT, 32'h0);
        st(32'h0);
        // High data bits set with a small low part must still clamp
        wr(udtc_pkg::ADDR_TARGET, 32'h80000005);
        rd(udtc_pkg::ADDR_TARGET, 32'h0001869f);
        $display("mid-run reset and clamp done");
        stop_test();
    end
endmodule
`default_nettype wire
